// ---- common/fas_pkg.sv ----
// Purpose: Shared constants for the fault and address space select block
// Assumes: Avalon-MM slave with 32-bit data, word aligned registers
// Notes: Offsets are byte addresses
package fas_pkg;
  localparam int PASID_W = 20;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GEN_CAP = 8'h04;
  localparam logic [7:0] OFS_XD_CAP = 8'h08;
  localparam logic [7:0] OFS_OP_CAP = 8'h0c;
  localparam logic [7:0] OFS_WQ_CFG = 8'h10;
  localparam logic [7:0] OFS_SWERR = 8'h14;
  localparam logic [7:0] OFS_SWERR_ADDR = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  // Control register bits
  localparam int CTRL_PRS_EN = 0;
  localparam int CTRL_PASID_EN = 1;
  localparam int CTRL_EVLOG_EN = 2;
  localparam int CTRL_WQ_PRS_DIS = 3;
  localparam int CTRL_WQ_SHARED = 4;
  // Interrupt status bits
  localparam int IRQ_EVLOG = 0;
  localparam int IRQ_SWERR = 1;
  localparam int IRQ_PARTIAL = 2;
  localparam int IRQ_W = 3;
  localparam int GEN_XD_BIT = 0;
  localparam logic [31:0] XD_CAP_VAL = 32'h0000_0002;
  localparam logic [31:0] OP_CAP_VAL = 32'h0000_0001;
  // Completion status codes
  localparam logic [1:0] ST_OK = 2'h1;
  localparam logic [1:0] ST_PARTIAL = 2'h2;
  localparam logic [1:0] ST_XD_ERR = 2'h3;
endpackage

// ---- verilog/fas_pasid_sel.sv ----
// Purpose: Picks the PASID that tags one address class
// Assumes: Permission result valid with the request
// Notes: Pure combinational select
`timescale 1ns/10ps
module fas_pasid_sel #(
  parameter int W = 20
) (
  input wire logic pasid_en, // PASID capability on
  input wire logic alt_sel, // Descriptor asks for alternate space
  input wire logic perm_ok, // Submitter permitted
  input wire logic [W-1:0] desc_pasid, // Descriptor PASID
  input wire logic [W-1:0] alt_pasid, // Requested access PASID
  output logic tag_valid, // PASID carried on the request
  output logic [W-1:0] tag_pasid // PASID to carry
);
  // Alternate only when enabled and permitted, else descriptor PASID
  always_comb begin
    tag_valid = pasid_en; // RULE9
    tag_pasid = (pasid_en && alt_sel && perm_ok) ? alt_pasid : desc_pasid; // RULE14 RULE15
  end
endmodule

// ---- verilog/fas_top.sv ----
// Operation
// RULE1: Page requests off when link enable is 0 or queue disable is 1.
// RULE2: Wait-on-fault 0 turns page requests off for source and destination only.
// RULE3: Completion record fault goes to event log if enabled, else software log.
// RULE4: Event log fault completes descriptor with record address and contents.
// RULE5: Software log holds one error; descriptor not completed, no progress kept.
// RULE6: Other address fault halts, writes partial status, address and progress.
// RULE7: Default PASID from descriptor on shared queue, from config on dedicated.
// RULE8: Accesses tagged with descriptor PASID unless access PASID applies.
// RULE9: With PASID off no PASID is carried; requester ID identifies space.
// RULE10: Cross-domain operations allowed only with PASID enabled.
// RULE11: General capability bit shows support; cross-domain register reports details.
// RULE12: Software uses cross-domain op codes only when capability supported.
// RULE13: With PASID on, source, destination or both may use alternate space.
// RULE14: Without alternate selection the descriptor PASID tags that address.
// RULE15: Permitted alternate selection tags that address with the access PASID.
// RULE16: Completion record, interrupts and permission checks use descriptor PASID.
// RULE17: Owner window reachable only with owner PASID as access PASID.
// RULE18: Up to two access PASIDs plus the descriptor PASID per operation.
// RULE19: With page requests on, faulting descriptor waits for the response.
// Purpose: Fault routing and address space selection for one work queue
// Assumes: Descriptor and fault inputs are same-clock logic
// Notes: Registers reached over Avalon-MM with waitrequest
`timescale 1ns/10ps
module fas_top #(
  parameter int PW = fas_pkg::PASID_W,
  parameter logic [31:0] GEN_CAP_VAL = 32'h0000_0001 // Cross-domain supported
) (
  input wire logic clock, // 250 MHz clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [7:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte enables
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic irq, // Level interrupt
  input wire logic desc_valid, // Descriptor offered
  input wire logic [PW-1:0] desc_pasid_in, // PASID carried by descriptor
  input wire logic desc_wait_fault, // Wait-on-fault flag
  input wire logic desc_xd, // Cross-domain operation
  input wire logic desc_src_alt, // Source uses alternate space
  input wire logic desc_dst_alt, // Destination uses alternate space
  input wire logic [PW-1:0] src_access_pasid, // Source access PASID
  input wire logic [PW-1:0] dst_access_pasid, // Destination access PASID
  input wire logic src_perm_ok, // Source permission check passed
  input wire logic dst_perm_ok, // Destination permission check passed
  input wire logic src_window, // Source falls in owner window
  input wire logic dst_window, // Destination falls in owner window
  input wire logic [PW-1:0] src_owner_pasid, // Owner of source window
  input wire logic [PW-1:0] dst_owner_pasid, // Owner of destination window
  output logic desc_ready, // Descriptor accepted
  output logic src_prs_en, // Page requests allowed for source
  output logic dst_prs_en, // Page requests allowed for destination
  output logic other_prs_en, // Page requests allowed for other addresses
  output logic src_tag_valid, // Source carries PASID
  output logic [PW-1:0] src_tag_pasid, // Source PASID tag
  output logic dst_tag_valid, // Destination carries PASID
  output logic [PW-1:0] dst_tag_pasid, // Destination PASID tag
  output logic cr_tag_valid, // Completion record carries PASID
  output logic [PW-1:0] cr_tag_pasid, // Completion record and interrupt PASID
  input wire logic fault_valid, // Translation fault pulse
  input wire logic fault_is_cr, // Fault on completion record address
  input wire logic fault_is_buf, // Fault on source or destination buffer
  input wire logic [63:0] fault_addr, // Faulting address
  input wire logic [31:0] fault_progress, // Bytes done before fault
  input wire logic [63:0] cr_addr, // Completion record address
  output logic prs_req, // Page request pulse
  input wire logic prs_resp, // Page request response pulse
  output logic evlog_wr, // Event log write pulse
  output logic [63:0] evlog_addr, // Logged record address
  output logic [31:0] evlog_data, // Logged record contents
  output logic cr_wr, // Completion record write pulse
  output logic [1:0] cr_status, // Completion status
  output logic [63:0] cr_fault_addr, // Faulting address in record
  output logic [31:0] cr_progress, // Progress in record
  output logic busy // Descriptor in flight
);
  localparam int IRQ_W_C = fas_pkg::IRQ_W;
  typedef enum logic [1:0] {FAS_IDLE, FAS_RUN, FAS_WAIT_PRS} fas_state_e;
  typedef struct packed {
    fas_state_e state;
    logic [4:0] ctrl;
    logic [PW-1:0] wq_pasid;
    logic [PW-1:0] cur_pasid;
    logic wait_fault;
    logic swerr_valid;
    logic [63:0] swerr_addr;
    logic [IRQ_W_C-1:0] irq_stat;
    logic [IRQ_W_C-1:0] irq_mask;
    logic [31:0] rdata;
    logic ack;
    logic prs_req;
    logic evlog_wr;
    logic [63:0] evlog_addr;
    logic [31:0] evlog_data;
    logic cr_wr;
    logic [1:0] cr_status;
    logic [63:0] cr_fault_addr;
    logic [31:0] cr_progress;
  } fas_state_s;

  fas_state_s cur_ff;
  fas_state_s nxt_ff;
  logic [1:0] rst_sync_ff; // Apart from the state, it runs before the internal reset lifts
  logic rst_n;
  logic pasid_on;
  logic prs_global;
  logic [PW-1:0] dflt_pasid;
  logic acc;
  logic [31:0] wmask;
  logic src_alt_ok;
  logic dst_alt_ok;

  // Reset release through two flip-flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Derived enables
  assign pasid_on = cur_ff.ctrl[fas_pkg::CTRL_PASID_EN];
  assign prs_global = cur_ff.ctrl[fas_pkg::CTRL_PRS_EN] &&
                      !cur_ff.ctrl[fas_pkg::CTRL_WQ_PRS_DIS]; // RULE1
  assign dflt_pasid = cur_ff.ctrl[fas_pkg::CTRL_WQ_SHARED] ? desc_pasid_in
                      : cur_ff.wq_pasid; // RULE7
  assign acc = (avs_read || avs_write) && !cur_ff.ack;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // Alternate space only with PASID on and, in a window, only as owner
  assign src_alt_ok = src_perm_ok && (!src_window ||
                      src_owner_pasid == src_access_pasid); // RULE17
  assign dst_alt_ok = dst_perm_ok && (!dst_window ||
                      dst_owner_pasid == dst_access_pasid); // RULE17

  // Next state
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.ack = acc;
    nxt_ff.prs_req = 1'b0;
    nxt_ff.evlog_wr = 1'b0;
    nxt_ff.cr_wr = 1'b0;
    // Register reads
    if (acc && avs_read) begin
      unique case (avs_address)
        fas_pkg::OFS_CTRL: nxt_ff.rdata = {27'h0, cur_ff.ctrl};
        fas_pkg::OFS_GEN_CAP: nxt_ff.rdata = GEN_CAP_VAL; // RULE11
        fas_pkg::OFS_XD_CAP: nxt_ff.rdata = GEN_CAP_VAL[fas_pkg::GEN_XD_BIT] ?
                                           fas_pkg::XD_CAP_VAL : 32'h0; // RULE11
        fas_pkg::OFS_OP_CAP: nxt_ff.rdata = GEN_CAP_VAL[fas_pkg::GEN_XD_BIT] ?
                                           fas_pkg::OP_CAP_VAL : 32'h0; // RULE11
        fas_pkg::OFS_WQ_CFG: nxt_ff.rdata = 32'(cur_ff.wq_pasid);
        fas_pkg::OFS_SWERR: nxt_ff.rdata = {31'h0, cur_ff.swerr_valid};
        fas_pkg::OFS_SWERR_ADDR: nxt_ff.rdata = cur_ff.swerr_addr[31:0];
        fas_pkg::OFS_IRQ_STAT: nxt_ff.rdata = 32'(cur_ff.irq_stat);
        fas_pkg::OFS_IRQ_MASK: nxt_ff.rdata = 32'(cur_ff.irq_mask);
        default: nxt_ff.rdata = 32'h0;
      endcase
    end
    // Register writes
    if (acc && avs_write) begin
      unique case (avs_address)
        fas_pkg::OFS_CTRL: nxt_ff.ctrl = (cur_ff.ctrl & ~wmask[4:0]) |
                                         (avs_writedata[4:0] & wmask[4:0]);
        fas_pkg::OFS_WQ_CFG: nxt_ff.wq_pasid = (cur_ff.wq_pasid & ~wmask[PW-1:0]) |
                                              (avs_writedata[PW-1:0] & wmask[PW-1:0]);
        fas_pkg::OFS_SWERR: if (avs_writedata[0] && avs_byteenable[0]) begin
          nxt_ff.swerr_valid = 1'b0;
        end
        fas_pkg::OFS_IRQ_STAT: nxt_ff.irq_stat = cur_ff.irq_stat &
                                                ~avs_writedata[IRQ_W_C-1:0];
        fas_pkg::OFS_IRQ_MASK: nxt_ff.irq_mask = avs_writedata[IRQ_W_C-1:0];
        default: ;
      endcase
    end
    // Descriptor flow
    unique case (cur_ff.state)
      FAS_IDLE: begin
        if (desc_valid) begin
          nxt_ff.cur_pasid = dflt_pasid;
          nxt_ff.wait_fault = desc_wait_fault;
          if (desc_xd && !pasid_on) begin
            nxt_ff.cr_wr = 1'b1; // RULE10
            nxt_ff.cr_status = fas_pkg::ST_XD_ERR;
          end else begin
            nxt_ff.state = FAS_RUN;
          end
        end
      end
      FAS_RUN: begin
        if (fault_valid) begin
          if ((fault_is_buf ? (prs_global && cur_ff.wait_fault) : prs_global)) begin
            nxt_ff.prs_req = 1'b1;
            nxt_ff.state = FAS_WAIT_PRS; // RULE19
          end else if (fault_is_cr) begin
            if (cur_ff.ctrl[fas_pkg::CTRL_EVLOG_EN]) begin
              nxt_ff.evlog_wr = 1'b1; // RULE3 RULE4
              nxt_ff.evlog_addr = cr_addr;
              nxt_ff.evlog_data = {30'h0, fas_pkg::ST_OK};
              nxt_ff.irq_stat[fas_pkg::IRQ_EVLOG] = 1'b1;
            end else begin
              if (!cur_ff.swerr_valid) begin
                nxt_ff.swerr_addr = cr_addr; // RULE5
              end
              nxt_ff.swerr_valid = 1'b1; // RULE3
              nxt_ff.irq_stat[fas_pkg::IRQ_SWERR] = 1'b1;
            end
            nxt_ff.state = FAS_IDLE;
          end else begin
            nxt_ff.cr_wr = 1'b1; // RULE6
            nxt_ff.cr_status = fas_pkg::ST_PARTIAL;
            nxt_ff.cr_fault_addr = fault_addr;
            nxt_ff.cr_progress = fault_progress;
            nxt_ff.irq_stat[fas_pkg::IRQ_PARTIAL] = 1'b1;
            nxt_ff.state = FAS_IDLE;
          end
        end else begin
          nxt_ff.cr_wr = 1'b1;
          nxt_ff.cr_status = fas_pkg::ST_OK;
          nxt_ff.cr_progress = 32'h0;
          nxt_ff.state = FAS_IDLE;
        end
      end
      FAS_WAIT_PRS: begin
        if (prs_resp) begin
          nxt_ff.state = FAS_RUN;
        end
      end
      default: nxt_ff.state = FAS_IDLE;
    endcase
  end

  // State register; sync flops kept in their own process
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff.state <= FAS_IDLE;
      cur_ff.ctrl <= 5'h0;
      cur_ff.wq_pasid <= '0;
      cur_ff.cur_pasid <= '0;
      cur_ff.wait_fault <= 1'b0;
      cur_ff.swerr_valid <= 1'b0;
      cur_ff.swerr_addr <= 64'h0;
      cur_ff.irq_stat <= '0;
      cur_ff.irq_mask <= '0;
      cur_ff.rdata <= 32'h0;
      cur_ff.ack <= 1'b0;
      cur_ff.prs_req <= 1'b0;
      cur_ff.evlog_wr <= 1'b0;
      cur_ff.evlog_addr <= 64'h0;
      cur_ff.evlog_data <= 32'h0;
      cur_ff.cr_wr <= 1'b0;
      cur_ff.cr_status <= 2'h0;
      cur_ff.cr_fault_addr <= 64'h0;
      cur_ff.cr_progress <= 32'h0;
    end else begin
      cur_ff.state <= nxt_ff.state;
      cur_ff.ctrl <= nxt_ff.ctrl;
      cur_ff.wq_pasid <= nxt_ff.wq_pasid;
      cur_ff.cur_pasid <= nxt_ff.cur_pasid;
      cur_ff.wait_fault <= nxt_ff.wait_fault;
      cur_ff.swerr_valid <= nxt_ff.swerr_valid;
      cur_ff.swerr_addr <= nxt_ff.swerr_addr;
      cur_ff.irq_stat <= nxt_ff.irq_stat;
      cur_ff.irq_mask <= nxt_ff.irq_mask;
      cur_ff.rdata <= nxt_ff.rdata;
      cur_ff.ack <= nxt_ff.ack;
      cur_ff.prs_req <= nxt_ff.prs_req;
      cur_ff.evlog_wr <= nxt_ff.evlog_wr;
      cur_ff.evlog_addr <= nxt_ff.evlog_addr;
      cur_ff.evlog_data <= nxt_ff.evlog_data;
      cur_ff.cr_wr <= nxt_ff.cr_wr;
      cur_ff.cr_status <= nxt_ff.cr_status;
      cur_ff.cr_fault_addr <= nxt_ff.cr_fault_addr;
      cur_ff.cr_progress <= nxt_ff.cr_progress;
    end
  end

  // Bus and event outputs
  assign avs_waitrequest = (avs_read || avs_write) && !cur_ff.ack;
  assign avs_readdata = cur_ff.rdata;
  assign irq = |(cur_ff.irq_stat & cur_ff.irq_mask);
  assign desc_ready = (cur_ff.state == FAS_IDLE);
  assign busy = (cur_ff.state != FAS_IDLE);
  assign prs_req = cur_ff.prs_req;
  assign evlog_wr = cur_ff.evlog_wr;
  assign evlog_addr = cur_ff.evlog_addr;
  assign evlog_data = cur_ff.evlog_data;
  assign cr_wr = cur_ff.cr_wr;
  assign cr_status = cur_ff.cr_status;
  assign cr_fault_addr = cur_ff.cr_fault_addr;
  assign cr_progress = cur_ff.cr_progress;

  // Page request enables per address class
  assign other_prs_en = prs_global; // RULE1
  assign src_prs_en = prs_global && cur_ff.wait_fault; // RULE2
  assign dst_prs_en = prs_global && cur_ff.wait_fault; // RULE2

  // Completion record and interrupts always use descriptor PASID
  assign cr_tag_valid = pasid_on; // RULE9 RULE16
  assign cr_tag_pasid = cur_ff.cur_pasid; // RULE16 RULE8

  // Source and destination tags, two access PASIDs at most
  fas_pasid_sel #(.W(PW)) u_src_sel (
    .pasid_en(pasid_on),
    .alt_sel(desc_src_alt), // RULE13
    .perm_ok(src_alt_ok),
    .desc_pasid(cur_ff.cur_pasid),
    .alt_pasid(src_access_pasid), // RULE18
    .tag_valid(src_tag_valid),
    .tag_pasid(src_tag_pasid)
  );
  fas_pasid_sel #(.W(PW)) u_dst_sel (
    .pasid_en(pasid_on),
    .alt_sel(desc_dst_alt), // RULE13
    .perm_ok(dst_alt_ok),
    .desc_pasid(cur_ff.cur_pasid),
    .alt_pasid(dst_access_pasid), // RULE18
    .tag_valid(dst_tag_valid),
    .tag_pasid(dst_tag_pasid)
  );

  // Checks
  AST_PRS_GATE: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
    (!cur_ff.ctrl[fas_pkg::CTRL_PRS_EN] || cur_ff.ctrl[fas_pkg::CTRL_WQ_PRS_DIS])
    |-> !other_prs_en && !src_prs_en && !dst_prs_en) else $error("page requests not disabled");
  AST_BUF_PRS: assert property (@(posedge clock) disable iff (!rst_n) // RULE2
    !cur_ff.wait_fault |-> !src_prs_en && !dst_prs_en) else $error("buffer prs on");
  AST_EVLOG: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
    (cur_ff.state == FAS_RUN && fault_valid && fault_is_cr && !fault_is_buf &&
     !prs_global && cur_ff.ctrl[fas_pkg::CTRL_EVLOG_EN])
    |=> evlog_wr && evlog_addr == $past(cr_addr)) else $error("event log missed");
  AST_SWERR: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
    (cur_ff.state == FAS_RUN && fault_valid && fault_is_cr && !fault_is_buf &&
     !prs_global && !cur_ff.ctrl[fas_pkg::CTRL_EVLOG_EN])
    |=> cur_ff.swerr_valid && !cr_wr) else $error("software log wrong");
  AST_PARTIAL: assert property (@(posedge clock) disable iff (!rst_n) // RULE6
    (cur_ff.state == FAS_RUN && fault_valid && !fault_is_cr && !prs_global)
    |=> cr_wr && cr_status == fas_pkg::ST_PARTIAL) else $error("partial missed");
  AST_NO_PASID: assert property (@(posedge clock) disable iff (!rst_n) // RULE9
    !pasid_on |-> !src_tag_valid && !dst_tag_valid && !cr_tag_valid)
    else $error("pasid carried while off");
  AST_XD_OFF: assert property (@(posedge clock) disable iff (!rst_n) // RULE10
    (desc_ready && desc_valid && desc_xd && !pasid_on)
    |=> cr_wr && cr_status == fas_pkg::ST_XD_ERR && desc_ready) else $error("xd ran w/o pasid");
  AST_DFLT: assert property (@(posedge clock) disable iff (!rst_n) // RULE14
    !desc_src_alt |-> src_tag_pasid == cur_ff.cur_pasid) else $error("wrong source tag");
  sequence seq_fault_prs;
    cur_ff.state == FAS_RUN && fault_valid && !fault_is_cr && prs_global &&
    (!fault_is_buf || cur_ff.wait_fault);
  endsequence
  sequence seq_wait;
    prs_req ##0 (busy && !desc_ready);
  endsequence
  AST_HOLD: assert property (@(posedge clock) disable iff (!rst_n) // RULE19
    seq_fault_prs |=> seq_wait) else $error("fault not held");
endmodule

// ---- verification/fas_host_model.sv ----
// Purpose: Host side that answers page requests from the block
// Assumes: One page request outstanding at a time
// Notes: slow picks a late answer instead of a prompt one
`timescale 1ns/10ps
module fas_host_model (
  input wire logic clock, // Bench clock
  input wire logic reset_n, // Active low reset
  input wire logic prs_req, // Page request pulse
  input wire logic slow, // Answer late
  output logic prs_resp // Page request response pulse
);
  int cnt;
  // Count from request to a one-cycle response pulse
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      prs_resp <= 1'b0;
    end else begin
      prs_resp <= (cnt == 1);
      if (prs_req) begin
        cnt <= slow ? 24 : 2;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// ---- verification/fault_and_address_space_select_tb.sv ----
// Purpose: Self-checking bench for fault routing and PASID selection
// Assumes: One wait state per bus access, descriptors one at a time
// Notes: Results are queued by the driver and matched by a monitor
`timescale 1ns/10ps
module fault_and_address_space_select_tb;
  typedef struct packed {logic ev; logic [1:0] st; logic [63:0] a; logic [31:0] p;} fas_exp_s;
  logic clock, reset_n, avs_read, avs_write, avs_waitrequest, irq, desc_valid, desc_ready;
  logic desc_wait_fault, desc_xd, desc_src_alt, desc_dst_alt, src_perm_ok, dst_perm_ok;
  logic src_window, dst_window, src_prs_en, dst_prs_en, other_prs_en, src_tag_valid;
  logic dst_tag_valid, cr_tag_valid, fault_valid, fault_is_cr, fault_is_buf, prs_req;
  logic prs_resp, evlog_wr, cr_wr, busy, slow, e_tv, e_oth, e_buf, do_tag;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [1:0] cr_status;
  logic [31:0] avs_writedata, avs_readdata, fault_progress, evlog_data, cr_progress, rd, lf;
  logic [19:0] desc_pasid_in, src_access_pasid, dst_access_pasid, src_owner_pasid;
  logic [19:0] dst_owner_pasid, src_tag_pasid, dst_tag_pasid, cr_tag_pasid;
  logic [19:0] e_src, e_dst, e_cr, p0, p1, p2;
  logic [63:0] fault_addr, cr_addr, evlog_addr, cr_fault_addr, a0, a1;
  int n_fail, compares, n_prs;
  fas_exp_s q[$];
  fas_exp_s x;
  localparam logic [7:0] RA [4] = '{fas_pkg::OFS_GEN_CAP, fas_pkg::OFS_XD_CAP,
    fas_pkg::OFS_OP_CAP, 8'h3c};
  localparam logic [31:0] RV [4] = '{32'h1, fas_pkg::XD_CAP_VAL, fas_pkg::OP_CAP_VAL, 32'h0};
  localparam logic [31:0] CT [3] = '{32'h9, 32'h1, 32'h0};

  fas_top i_dut (.*);
  fas_host_model i_host (.clock(clock), .reset_n(reset_n), .prs_req(prs_req),
    .slow(slow), .prs_resp(prs_resp));

  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction

  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Avalon-MM access held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clock);
      n++;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 50) begin
      n_fail++;
      wrap_up();
    end
    @(posedge clock);
  endtask

  // One descriptor, optional fault in its run cycle, wait until idle
  task automatic run_desc(input logic fv);
    int n;
    n = 0;
    desc_valid <= 1'b1;
    @(posedge clock);
    desc_valid <= 1'b0;
    fault_valid <= fv;
    #1;
    if (do_tag && e_tv) begin
      chk("tags", {e_src, e_dst, e_cr}, {src_tag_pasid, dst_tag_pasid, cr_tag_pasid});
    end
    if (do_tag) begin
      chk("prs_en", {e_buf, e_buf, e_oth}, {src_prs_en, dst_prs_en, other_prs_en});
    end
    @(posedge clock);
    fault_valid <= 1'b0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clock);
      n++;
    end
    if (n == 100) begin
      n_fail++;
      wrap_up();
    end
    repeat (2) @(posedge clock);
  endtask

  // Result monitor against the oldest queued expectation
  always @(posedge clock) begin
    if (prs_req === 1'b1) n_prs++;
    if (cr_wr === 1'b1 || evlog_wr === 1'b1) begin
      if (q.size() == 0) begin
        n_fail++;
        $display("MISMATCH result expected none seen cr %b ev %b", cr_wr, evlog_wr);
      end else begin
        x = q.pop_front();
        compares++;
        if (x.ev) chk("evlog", {1'b1, x.a, x.p}, {evlog_wr, evlog_addr, evlog_data});
        else chk("cr_status", {1'b1, x.st}, {cr_wr, cr_status});
        if (!x.ev && x.st == fas_pkg::ST_PARTIAL) chk("cr_fault", {x.a, x.p},
          {cr_fault_addr, cr_progress});
      end
    end
  end

  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Main sequence
  initial begin
    {reset_n, avs_read, avs_write, desc_valid, desc_wait_fault, desc_xd, desc_src_alt} = '0;
    {desc_dst_alt, src_perm_ok, dst_perm_ok, src_window, dst_window, fault_valid} = '0;
    {fault_is_cr, fault_is_buf, slow, avs_address, avs_writedata, fault_progress} = '0;
    {desc_pasid_in, src_access_pasid, dst_access_pasid, src_owner_pasid} = '0;
    {dst_owner_pasid, fault_addr, cr_addr, n_fail, compares, n_prs} = '0;
    avs_byteenable = 4'hf;
    lf = 32'h2d;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    bus(1'b1, 8'h3c, 32'hffffffff);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, RA[i], 32'h0);
      chk("cap_reg", RV[i], rd);
    end
    $display("test capabilities done");
    p0 = 20'(rnd());
    p1 = 20'(rnd());
    p2 = 20'(rnd());
    bus(1'b1, fas_pkg::OFS_CTRL, 32'h12);
    {desc_pasid_in, src_access_pasid, src_owner_pasid, dst_access_pasid} <= {p0, p1, p1, p2};
    {desc_xd, desc_src_alt, desc_dst_alt, src_perm_ok, dst_perm_ok, src_window} <= 6'h3f;
    {e_tv, e_src, e_dst, e_cr, e_oth, e_buf, do_tag} = {1'b1, p1, p2, p0, 3'b001};
    q.push_back({1'b0, fas_pkg::ST_OK, 96'h0});
    run_desc(1'b0);
    $display("test shared queue alternate spaces done");
    bus(1'b1, fas_pkg::OFS_CTRL, 32'h2);
    bus(1'b1, fas_pkg::OFS_WQ_CFG, 32'(p2));
    {desc_xd, desc_src_alt, desc_dst_alt} <= 3'b000;
    {e_src, e_dst, e_cr} = {p2, p2, p2};
    q.push_back({1'b0, fas_pkg::ST_OK, 96'h0});
    run_desc(1'b0);
    $display("test dedicated queue done");
    bus(1'b1, fas_pkg::OFS_CTRL, 32'h0);
    chk("tag_valid", 3'b000, {src_tag_valid, dst_tag_valid, cr_tag_valid});
    {desc_xd, do_tag, e_tv} <= 3'b100;
    q.push_back({1'b0, fas_pkg::ST_XD_ERR, 96'h0});
    run_desc(1'b0);
    $display("test cross domain refused done");
    bus(1'b1, fas_pkg::OFS_CTRL, 32'h1);
    {desc_xd, desc_wait_fault, fault_is_buf, slow, do_tag} <= 5'h0f;
    {e_oth, e_buf} = 2'b11;
    q.push_back({1'b0, fas_pkg::ST_OK, 96'h0});
    run_desc(1'b1);
    chk("prs_req_count", 1, n_prs);
    $display("test page request wait done");
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, fas_pkg::OFS_CTRL, CT[i]);
      a0 = {rnd(), rnd()};
      fault_addr <= a0;
      fault_progress <= lf;
      desc_wait_fault <= (i != 1);
      {e_oth, e_buf} = {i == 1, 1'b0};
      q.push_back({1'b0, fas_pkg::ST_PARTIAL, a0, lf});
      run_desc(1'b1);
    end
    chk("prs_req_count", 1, n_prs);
    chk("irq_masked", 1'b0, irq);
    bus(1'b1, fas_pkg::OFS_IRQ_MASK, 32'h4);
    chk("irq_raised", 1'b1, irq);
    bus(1'b1, fas_pkg::OFS_IRQ_STAT, 32'h4);
    chk("irq_cleared", 1'b0, irq);
    $display("test partial completion done");
    bus(1'b1, fas_pkg::OFS_CTRL, 32'h4);
    {fault_is_buf, fault_is_cr, do_tag} <= 3'b010;
    {cr_addr, fault_addr} <= {a0, a0};
    q.push_back({1'b1, 2'h0, a0, 32'(fas_pkg::ST_OK)});
    run_desc(1'b1);
    bus(1'b1, fas_pkg::OFS_CTRL, 32'h0);
    a1 = {rnd(), rnd()};
    {cr_addr, fault_addr} <= {a1, a1};
    run_desc(1'b1);
    {cr_addr, fault_addr} <= {a0, a0};
    run_desc(1'b1);
    bus(1'b0, fas_pkg::OFS_SWERR, 32'h0);
    chk("swerr", 1'b1, rd[0]);
    bus(1'b0, fas_pkg::OFS_SWERR_ADDR, 32'h0);
    chk("swerr_addr", a1[31:0], rd);
    bus(1'b0, fas_pkg::OFS_IRQ_STAT, 32'h0);
    chk("irq_stat", 32'h3, rd);
    chk("pending", 0, q.size());
    $display("test completion record faults done");
    wrap_up();
  end
endmodule
